// >>> rtl/comparator_control_pkg.sv
// ==========================================================
// shared constants and carriers for the comparator block
package comparator_control_pkg;
  // ==========================================================
  // bus geometry
  localparam int ADDR_W = 10; // byte address width
  localparam int DATA_W = 32; // data width
  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_COMPARATOR_ONE_CONTROL = 8'hA0; // comparator one control
  localparam logic [7:0] IDX_COMPARATOR_TWO_CONTROL = 8'hA1; // comparator two control
  localparam logic [7:0] IDX_IRQ_EN = 8'hA2; // irq enables
  localparam logic [7:0] IDX_CLOCK = 8'hA3; // divider and timing mode
  localparam logic [7:0] IDX_EVT_STAT = 8'hA4; // sticky event status
  localparam logic [7:0] IDX_EVT_MASK = 8'hA5; // event mask
  localparam logic [7:0] IDX_P0_OFF = 8'hF6; // port 0 digital input off
  // ==========================================================
  // comparator control field positions
  localparam int CMF_BIT = 0; // change flag
  localparam int OUT_BIT = 1; // result, read only
  localparam int OE_BIT = 2; // result pin enable
  localparam int CN_BIT = 3; // negative input select
  localparam int CP_BIT = 4; // positive input select
  localparam int EN_BIT = 5; // comparator enable
  localparam int SETTLED_BIT = 6; // start-up settling done, read only
  // irq enable fields
  localparam int EC1_BIT = 0; // comparator one irq enable
  localparam int EC2_BIT = 1; // comparator two irq enable
  localparam int EA_BIT = 7; // global irq enable
  // clock register fields
  localparam int STD_BIT = 8; // standard timing select
  // ==========================================================
  // reset values
  localparam logic [7:0] P0_OFF_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h00;
  // ==========================================================
  // timing
  localparam logic [3:0] MC_FAST = 4'h6; // cpu clocks per machine cycle
  localparam logic [3:0] MC_STD = 4'hC; // same in standard timing
  localparam int CLK_PERIOD_PS = 25000; // 40 MHz reference
  localparam int SETTLE_NS = 10000; // comparator start-up time
  localparam int SETTLE_CYC = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETTLE_W = $clog2(SETTLE_CYC + 1);
  // ==========================================================
  // carriers
  typedef struct packed {
    logic en; // comparator powered
    logic pos_sel; // 0 pin a, 1 pin b
    logic neg_sel; // 0 reference pin, 1 internal reference
    logic pin_en; // drive result to its pin
  } cmp_cfg_t;
  typedef struct packed {
    logic gt_b_int; // pin b above internal reference
    logic gt_b_pin; // pin b above reference pin
    logic gt_a_int; // pin a above internal reference
    logic gt_a_pin; // pin a above reference pin
  } cmp_sense_t;
endpackage : comparator_control_pkg

// >>> rtl/comparator_control_and_irq.sv
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
// Contract
// [RL1] machine cycle six periods by default
// [RL2] standard timing stretches cycle to twelve
// [RL3] cpu clock divided by divider register
// [RL4] one disable bit per port 0 pin
// [RL5] disabled port bits read as zero
// [RL6] result high when positive exceeds negative
// [RL7] positive from two pins, negative pin/reference
// [RL8] three bits give eight configurations
// [RL9] two comparators, identical control layouts
// [RL10] result readable and optionally driven out
// [RL11] result unreliable ten microseconds after enable
// [RL12] software clears flag before enabling irq
// [RL13] flag set on any result change
// [RL14] irq needs flag, own enable, global enable
// [RL15] comparators keep running in sleep modes
// [RL16] enabled change in sleep raises wake
// [RL17] handler clears flag before returning
// [RL18] port 0 disable register resets zero
// [RL19] flag sticky, cleared by writing zero
module comparator_control_and_irq
  import comparator_control_pkg::*;
#(
  parameter int DIV_W = 8,
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire cmp_sense_t [1:0] i_cmp_sense,
  input wire logic [7:0] i_port0_pins,
  input wire logic i_power_down,
  output logic [1:0] o_cmp_enable,
  output logic [1:0] o_cmp_pin,
  output logic [1:0] o_cmp_pin_oe,
  output logic [7:0] o_port0_input_off,
  output logic [7:0] o_port0_read,
  output logic o_cmp_irq,
  output logic o_wake,
  output logic o_irq,
  output logic o_cpu_clk_en,
  output logic o_machine_cycle
);
  // ==========================================================
  // bus slave: one wait cycle, then the access edge
  logic wait_ff; // waitrequest register
  logic [DATA_W-1:0] rdata_ff; // read data register
  logic [DATA_W-1:0] rd_mux; // selected read value
  logic [7:0] idx; // word index of the request
  logic req; // any request pending
  logic wr_en; // write takes effect this edge
  logic wr_lo; // low byte lane written
  assign idx = i_avs_address[9:2];
  assign req = i_avs_read | i_avs_write;
  assign wr_en = i_avs_write & ~wait_ff;
  assign wr_lo = wr_en & i_avs_byteenable[0];

  // waitrequest drops for one cycle per request
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      wait_ff <= 1'b1;
    end else if (i_clk_en) begin
      wait_ff <= ~(req & wait_ff);
    end
  end

  // read data is captured while waitrequest is still high
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rdata_ff <= '0;
    end else if (i_clk_en && i_avs_read && wait_ff) begin
      rdata_ff <= rd_mux;
    end
  end
  assign o_avs_readdata = rdata_ff;
  assign o_avs_waitrequest = wait_ff;

  // ==========================================================
  // input synchronisers, second stage only is read
  logic [7:0] sense_s1_ff; // first stage
  logic [7:0] sense_s2_ff; // second stage
  logic [7:0] pins_s1_ff; // first stage
  logic [7:0] pins_s2_ff; // second stage
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sense_s1_ff <= '0;
      sense_s2_ff <= '0;
      pins_s1_ff <= '0;
      pins_s2_ff <= '0;
    end else if (i_clk_en) begin
      sense_s1_ff <= i_cmp_sense;
      sense_s2_ff <= sense_s1_ff;
      pins_s1_ff <= i_port0_pins;
      pins_s2_ff <= pins_s1_ff;
    end
  end

  // ==========================================================
  // port 0 digital input disable
  logic [7:0] p0_off_ff; // one bit per pin
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      p0_off_ff <= P0_OFF_RST; // RL18
    end else if (i_clk_en && wr_lo && idx == IDX_P0_OFF) begin
      p0_off_ff <= i_avs_writedata[7:0]; // RL4
    end
  end

  // disabled pins read zero whatever their level
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_port0_read <= '0;
      o_port0_input_off <= P0_OFF_RST;
    end else if (i_clk_en) begin
      o_port0_read <= pins_s2_ff & ~p0_off_ff; // RL5
      o_port0_input_off <= p0_off_ff; // RL4
    end
  end

  // ==========================================================
  // clock divider and machine cycle
  logic [DIV_W-1:0] div_ff; // divider setting
  logic std_ff; // standard timing selected
  logic [DIV_W-1:0] div_cnt_ff; // divider count
  logic [3:0] mc_cnt_ff; // cpu clocks within machine cycle
  logic [3:0] mc_len; // machine cycle length
  logic cpu_tick; // one cpu clock elapses
  assign mc_len = std_ff ? MC_STD : MC_FAST; // RL1 RL2
  // wrap also when a smaller divider lands below the count, no long stall
  assign cpu_tick = (div_cnt_ff >= div_ff);

  // clock settings written by software
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      div_ff <= DIV_W'(DIV_RST);
      std_ff <= 1'b0;
    end else if (i_clk_en && wr_en && idx == IDX_CLOCK) begin
      if (i_avs_byteenable[0]) begin
        div_ff <= i_avs_writedata[DIV_W-1:0];
      end
      if (i_avs_byteenable[1]) begin
        std_ff <= i_avs_writedata[STD_BIT];
      end
    end
  end

  // cpu clock is the reference divided by setting plus one
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      div_cnt_ff <= '0;
      o_cpu_clk_en <= 1'b0;
    end else if (i_clk_en) begin
      div_cnt_ff <= cpu_tick ? '0 : div_cnt_ff + 1'b1; // RL3
      o_cpu_clk_en <= cpu_tick;
    end
  end

  // count cpu clocks into machine cycles
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      mc_cnt_ff <= '0;
      o_machine_cycle <= 1'b0;
    end else if (i_clk_en) begin
      o_machine_cycle <= cpu_tick && (mc_cnt_ff == mc_len - 4'h1); // RL1 RL2
      if (cpu_tick) begin
        // a shortened length mid-cycle wraps at once, no long stall
        mc_cnt_ff <= (mc_cnt_ff >= mc_len - 4'h1) ? 4'h0 : mc_cnt_ff + 4'h1;
      end
    end
  end

  // ==========================================================
  // comparators, identical per instance
  cmp_cfg_t [1:0] cfg_ff; // control fields
  logic [1:0] result_ff; // selected comparison
  logic [1:0] flag_ff; // sticky change flag
  logic [1:0] settled_ff; // start-up time passed
  logic [1:0] change; // result changed this edge
  logic [1:0] raw; // selected comparison before enable
  logic [1:0] wr_cmp; // control register written

  for (genvar g = 0; g < 2; g++) begin : g_cmp
    logic [SETTLE_W-1:0] settle_cnt_ff; // time since enable
    logic [3:0] pair; // this comparator's four comparisons
    assign pair = sense_s2_ff[g*4 +: 4];
    assign wr_cmp[g] = wr_lo && idx == (g == 0 ? IDX_COMPARATOR_ONE_CONTROL : IDX_COMPARATOR_TWO_CONTROL); // RL9
    // select bits pick the pair of inputs compared
    assign raw[g] = pair[{cfg_ff[g].pos_sel, cfg_ff[g].neg_sel}]; // RL7 RL8
    assign change[g] = settled_ff[g] && (raw[g] & cfg_ff[g].en) != result_ff[g];

    // control fields written by software
    always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
        cfg_ff[g] <= '0;
      end else if (i_clk_en && wr_cmp[g]) begin
        cfg_ff[g] <= {i_avs_writedata[EN_BIT], i_avs_writedata[CP_BIT],
                      i_avs_writedata[CN_BIT], i_avs_writedata[OE_BIT]}; // RL8
      end
    end

    // settling counter restarts whenever the comparator is off
    always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
        settle_cnt_ff <= '0;
        settled_ff[g] <= 1'b0;
      end else if (i_clk_en) begin
        if (!cfg_ff[g].en) begin
          settle_cnt_ff <= '0;
          settled_ff[g] <= 1'b0;
        end else if (settle_cnt_ff == SETTLE_W'(SETTLE_CYCLES - 1)) begin
          settled_ff[g] <= 1'b1; // RL11
        end else begin
          settle_cnt_ff <= settle_cnt_ff + 1'b1;
        end
      end
    end

    // result held low until settled, keeps running in sleep
    always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
        result_ff[g] <= 1'b0;
      end else if (i_clk_en) begin
        result_ff[g] <= settled_ff[g] & cfg_ff[g].en & raw[g]; // RL6 RL11 RL15
      end
    end

    // change flag: set wins over a software clear
    always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
        flag_ff[g] <= 1'b0;
      end else if (i_clk_en) begin
        flag_ff[g] <= change[g] | (flag_ff[g] & ~(wr_cmp[g] & ~i_avs_writedata[CMF_BIT])); // RL13 RL19
      end
    end

    // pin drive and analog core enable
    always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
        o_cmp_pin[g] <= 1'b0;
        o_cmp_pin_oe[g] <= 1'b0;
        o_cmp_enable[g] <= 1'b0;
      end else if (i_clk_en) begin
        o_cmp_pin[g] <= result_ff[g] & cfg_ff[g].pin_en; // RL10
        o_cmp_pin_oe[g] <= cfg_ff[g].pin_en & cfg_ff[g].en; // RL10
        o_cmp_enable[g] <= cfg_ff[g].en;
      end
    end

    AST_RESULT: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RL6
      (i_clk_en && settled_ff[g] && cfg_ff[g].en) |=> (result_ff[g] == $past(raw[g])))
      else $error("comparator result does not follow selected inputs");
    AST_FLAG_SET: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RL13
      (i_clk_en && change[g]) |=> flag_ff[g])
      else $error("result change did not set the change flag");
    AST_STICKY: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RL19
      (i_clk_en && flag_ff[g] && !(wr_cmp[g] && !i_avs_writedata[CMF_BIT])) |=> flag_ff[g])
      else $error("change flag dropped without a software clear");
    AST_SETTLE: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RL11
      (i_clk_en && $rose(cfg_ff[g].en)) |-> !settled_ff[g] [*8])
      else $error("comparator settled too early after enable");
    AST_PIN: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RL10
      i_clk_en |=> (o_cmp_pin[g] == $past(result_ff[g] & cfg_ff[g].pin_en)))
      else $error("result pin does not follow result and enable");
  end

  // ==========================================================
  // interrupt enables and request
  logic [1:0] ec_ff; // per comparator enables
  logic ea_ff; // global enable
  logic irq_req; // comparator request before register
  assign irq_req = ea_ff & |(flag_ff & ec_ff); // RL14

  // enable bits written by software
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ec_ff <= '0;
      ea_ff <= 1'b0;
    end else if (i_clk_en && wr_lo && idx == IDX_IRQ_EN) begin
      ec_ff <= {i_avs_writedata[EC2_BIT], i_avs_writedata[EC1_BIT]};
      ea_ff <= i_avs_writedata[EA_BIT];
    end
  end

  // request and wake; wake is only meaningful while asleep
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_cmp_irq <= 1'b0;
      o_wake <= 1'b0;
    end else if (i_clk_en) begin
      o_cmp_irq <= irq_req; // RL14
      o_wake <= i_power_down & irq_req; // RL16
    end
  end

  // ==========================================================
  // sticky event status, write one to clear, masked level irq
  logic [1:0] evt_ff; // change events
  logic [1:0] mask_ff; // event mask
  logic wr_stat; // status written
  assign wr_stat = wr_lo && idx == IDX_EVT_STAT;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      evt_ff <= '0;
      mask_ff <= '0;
      o_irq <= 1'b0;
    end else if (i_clk_en) begin
      // a new event beats a clear in the same cycle
      evt_ff <= change | (evt_ff & ~(wr_stat ? i_avs_writedata[1:0] : 2'h0));
      if (wr_lo && idx == IDX_EVT_MASK) begin
        mask_ff <= i_avs_writedata[1:0];
      end
      o_irq <= |(evt_ff & mask_ff);
    end
  end

  // ==========================================================
  // read multiplexer, unmapped words read zero
  always_comb begin
    rd_mux = '0;
    case (idx)
      IDX_COMPARATOR_ONE_CONTROL, IDX_COMPARATOR_TWO_CONTROL: begin
        rd_mux[CMF_BIT] = flag_ff[idx[0]];
        rd_mux[OUT_BIT] = result_ff[idx[0]]; // RL10
        rd_mux[OE_BIT] = cfg_ff[idx[0]].pin_en;
        rd_mux[CN_BIT] = cfg_ff[idx[0]].neg_sel;
        rd_mux[CP_BIT] = cfg_ff[idx[0]].pos_sel;
        rd_mux[EN_BIT] = cfg_ff[idx[0]].en;
        rd_mux[SETTLED_BIT] = settled_ff[idx[0]];
      end
      IDX_IRQ_EN: begin
        rd_mux[EC1_BIT] = ec_ff[0];
        rd_mux[EC2_BIT] = ec_ff[1];
        rd_mux[EA_BIT] = ea_ff;
      end
      IDX_CLOCK: begin
        rd_mux[DIV_W-1:0] = div_ff;
        rd_mux[STD_BIT] = std_ff;
      end
      IDX_EVT_STAT: rd_mux[1:0] = evt_ff;
      IDX_EVT_MASK: rd_mux[1:0] = mask_ff;
      IDX_P0_OFF: rd_mux[7:0] = p0_off_ff;
      default: rd_mux = '0;
    endcase
  end

  // ==========================================================
  // checks on shared logic
  AST_MC_FAST: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RL1
    (i_clk_en && cpu_tick && !std_ff) |=> (o_machine_cycle == $past(mc_cnt_ff == 4'h5)))
    else $error("machine cycle not six cpu clocks");
  AST_MC_STD: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RL2
    (i_clk_en && cpu_tick && std_ff) |=> (o_machine_cycle == $past(mc_cnt_ff == 4'hB)))
    else $error("machine cycle not twelve cpu clocks");
  AST_DIV: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RL3
    (i_clk_en && div_cnt_ff < div_ff) |=> !o_cpu_clk_en)
    else $error("cpu clock enable outside divider wrap");
  AST_P0_ZERO: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RL5
    i_clk_en |=> ((o_port0_read & $past(p0_off_ff)) == 8'h00))
    else $error("disabled port bit read as one");
  AST_IRQ: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RL14
    i_clk_en |=> (o_cmp_irq == $past(ea_ff & |(flag_ff & ec_ff))))
    else $error("comparator irq not gated by flag and enables");
  AST_WAKE: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RL16
    (i_clk_en && i_power_down && irq_req) |=> o_wake)
    else $error("enabled change in sleep did not wake");
endmodule : comparator_control_and_irq

// >>> tb/comparator_analog_model.sv
`timescale 1ns/1ps
// ==========================================================
// analog comparator cores and port 0 pads as seen by the block
module comparator_analog_model
  import comparator_control_pkg::*;
#(
  parameter logic [7:0] INT_REF = 8'h80 // internal reference level, arbitrary scale
) (
  input wire logic [1:0][7:0] i_level_a, // pin a level per comparator
  input wire logic [1:0][7:0] i_level_b, // pin b level per comparator
  input wire logic [1:0][7:0] i_level_ref, // reference pin level per comparator
  input wire logic [7:0] i_pin_drive, // what the board drives on port 0
  input wire logic [1:0] i_cmp_pin, // result pins from the block
  input wire logic [1:0] i_cmp_pin_oe, // result pin drivers on
  output cmp_sense_t [1:0] o_cmp_sense,
  output logic [7:0] o_port0_pins
);
  // ==========================================================
  // strict greater-than, so equal levels give a low result
  // cores keep sensing whatever the cpu power state is
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      o_cmp_sense[k].gt_a_pin = i_level_a[k] > i_level_ref[k];
      o_cmp_sense[k].gt_a_int = i_level_a[k] > INT_REF;
      o_cmp_sense[k].gt_b_pin = i_level_b[k] > i_level_ref[k];
      o_cmp_sense[k].gt_b_int = i_level_b[k] > INT_REF;
    end
  end
  // ==========================================================
  // result pins share port 0 bits 6 and 0; an enabled driver wins the pad
  always_comb begin
    o_port0_pins = i_pin_drive;
    if (i_cmp_pin_oe[0]) begin
      o_port0_pins[6] = i_cmp_pin[0];
    end
    if (i_cmp_pin_oe[1]) begin
      o_port0_pins[0] = i_cmp_pin[1];
    end
  end
endmodule : comparator_analog_model

// >>> tb/comparator_control_and_irq_tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the comparator control block
module comparator_control_and_irq_tb_top;
  import comparator_control_pkg::*;
  localparam int SETTLE = 10; // shortened start-up count
  logic ref_clk, rst, avs_read, avs_write, power_down, clk_en;
  logic [ADDR_W-1:0] avs_address;
  logic [DATA_W-1:0] avs_writedata, readdata;
  logic waitreq, cmp_irq, wake, irq, cpu_tick, mcyc;
  logic [1:0] cmp_en, cmp_pin, cmp_pin_oe;
  logic [7:0] p0_off, p0_read, p0_pins, pin_drive;
  logic [1:0][7:0] lvl_a, lvl_b, lvl_ref; // analog levels per comparator
  cmp_sense_t [1:0] sense;
  int n_fail, tests_run;
  comparator_control_and_irq #(.DIV_W(8), .SETTLE_CYCLES(SETTLE)) uut (.i_ref_clk(ref_clk), .i_rst(rst),
    .i_clk_en(clk_en), .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata), .i_avs_byteenable(4'hF), .o_avs_readdata(readdata),
    .o_avs_waitrequest(waitreq), .i_cmp_sense(sense), .i_port0_pins(p0_pins), .i_power_down(power_down),
    .o_cmp_enable(cmp_en), .o_cmp_pin(cmp_pin), .o_cmp_pin_oe(cmp_pin_oe), .o_port0_input_off(p0_off),
    .o_port0_read(p0_read), .o_cmp_irq(cmp_irq), .o_wake(wake), .o_irq(irq), .o_cpu_clk_en(cpu_tick),
    .o_machine_cycle(mcyc));
  comparator_analog_model model (.i_level_a(lvl_a), .i_level_b(lvl_b), .i_level_ref(lvl_ref),
    .i_pin_drive(pin_drive), .i_cmp_pin(cmp_pin), .i_cmp_pin_oe(cmp_pin_oe), .o_cmp_sense(sense),
    .o_port0_pins(p0_pins));
  // ==========================================================
  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ==========================================================
  // verdict, reached from the main flow and from any timeout
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin // four-state compare so an x seen never matches an expected 0 or 1
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  // ==========================================================
  // one avalon access; holds everything until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= {idx, 2'b00};
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge ref_clk);
    while (waitreq !== 1'b0) begin
      n++;
      if (n > 20) begin // slave never answered
        n_fail++;
        close_out();
      end
      @(posedge ref_clk);
    end
    q = readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk); // idle edge so no signal is set twice in one step
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 32'h0, q);
    chk(nm, exp, q);
  endtask : rd
  // ==========================================================
  // port 0 input disable and an unmapped place
  task automatic port_scn();
    pin_drive <= 8'hFF;
    rd("p0 off reset", IDX_P0_OFF, 32'h0);
    wr(IDX_P0_OFF, 32'h30);
    rd("p0 off back", IDX_P0_OFF, 32'h30);
    tick(4);
    chk("p0 read", 32'hCF, {24'h0, p0_read});
    chk("p0 off pins", 32'h30, {24'h0, p0_off});
    wr(8'h10, 32'hFF);
    rd("unmapped", 8'h10, 32'h0);
  endtask : port_scn
  // ==========================================================
  // clock enable low freezes the pin path, then it catches up
  task automatic freeze_scn();
    clk_en <= 1'b0;
    pin_drive <= 8'h00;
    tick(6);
    chk("frozen read", 32'hCF, {24'h0, p0_read});
    clk_en <= 1'b1;
    tick(4);
    chk("thawed read", 32'h0, {24'h0, p0_read});
  endtask : freeze_scn
  // ==========================================================
  // comparator one: settle, flag, irq gating, wake, event status
  task automatic cmp_one_scn();
    lvl_a[0] <= 8'h32;
    lvl_ref[0] <= 8'h64;
    wr(IDX_COMPARATOR_ONE_CONTROL, 32'h24);
    tick(SETTLE + 4);
    chk("comparator_one_control enable", 32'h1, {31'h0, cmp_en[0]});
    rd("comparator_one_control settled", IDX_COMPARATOR_ONE_CONTROL, 32'h64);
    lvl_a[0] <= 8'h64;
    tick(6);
    rd("comparator_one_control equal", IDX_COMPARATOR_ONE_CONTROL, 32'h64);
    wr(IDX_IRQ_EN, 32'h81); // flag already clear
    tick(2);
    chk("irq quiet", 32'h0, {31'h0, cmp_irq});
    power_down <= 1'b1;
    lvl_a[0] <= 8'h96;
    tick(6);
    rd("comparator_one_control rise", IDX_COMPARATOR_ONE_CONTROL, 32'h67);
    chk("comparator_one_control pin", 32'h1, {31'h0, cmp_pin[0]});
    chk("cmp irq", 32'h1, {31'h0, cmp_irq});
    chk("wake", 32'h1, {31'h0, wake});
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(IDX_EVT_MASK, 32'h1);
    tick(2);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(IDX_EVT_STAT, 32'h1);
    tick(2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(IDX_IRQ_EN, 32'h01);
    tick(2);
    chk("global off", 32'h0, {31'h0, cmp_irq});
    lvl_a[0] <= 8'h32;
    tick(6);
    wr(IDX_COMPARATOR_ONE_CONTROL, 32'h25);
    rd("flag sticky", IDX_COMPARATOR_ONE_CONTROL, 32'h65);
    wr(IDX_COMPARATOR_ONE_CONTROL, 32'h24);
    rd("flag cleared", IDX_COMPARATOR_ONE_CONTROL, 32'h64);
    power_down <= 1'b0;
  endtask : cmp_one_scn
  // ==========================================================
  // comparator two through all eight configurations
  task automatic cmp_two_scn();
    logic cp, cn, oe;
    wr(IDX_COMPARATOR_TWO_CONTROL, 32'h20);
    tick(SETTLE + 4);
    for (int c = 0; c < 8; c++) begin
      {oe, cp, cn} = 3'(c);
      lvl_ref[1] <= cn ? 8'hFA : 8'h64; // beats a wrongly chosen negative
      lvl_a[1] <= cp ? 8'h00 : (cn ? 8'hC8 : 8'h78);
      lvl_b[1] <= cp ? (cn ? 8'hC8 : 8'h78) : 8'h00;
      wr(IDX_COMPARATOR_TWO_CONTROL, {26'h0, 1'b1, cp, cn, oe, 2'b00});
      tick(6);
      chk("comparator_two_control enable", 32'h1, {31'h0, cmp_en[1]});
      rd("comparator_two_control result", IDX_COMPARATOR_TWO_CONTROL, {25'h0, 1'b1, 1'b1, cp, cn, oe, 2'b11});
      chk("comparator_two_control pin", {31'h0, oe}, {31'h0, cmp_pin[1]});
      chk("comparator_two_control oe", {31'h0, oe}, {31'h0, cmp_pin_oe[1]});
      lvl_a[1] <= cp ? 8'hFF : 8'h00;
      lvl_b[1] <= cp ? 8'h00 : 8'hFF;
      wr(IDX_COMPARATOR_TWO_CONTROL, {26'h0, 1'b1, cp, cn, oe, 2'b00});
      tick(6);
      rd("comparator_two_control low", IDX_COMPARATOR_TWO_CONTROL, {25'h0, 1'b1, 1'b1, cp, cn, oe, 2'b01});
      wr(IDX_COMPARATOR_TWO_CONTROL, {26'h0, 1'b1, cp, cn, oe, 2'b00});
    end
  endtask : cmp_two_scn
  // ==========================================================
  // machine cycle length from divider and timing select
  task automatic wait_mc(output int n, output int t);
    n = 0;
    t = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (cpu_tick === 1'b1) begin
        t++;
      end
    end while (mcyc !== 1'b1 && n < 200);
    if (n >= 200) begin // machine cycle pulse never came
      n_fail++;
      close_out();
    end
  endtask : wait_mc
  task automatic mc_scn(input logic std, input logic [7:0] div, input int exp);
    int n;
    int t;
    wr(IDX_CLOCK, {23'h0, std, div});
    wait_mc(n, t);
    wait_mc(n, t);
    chk("machine cycle", 32'(exp), 32'(n));
    chk("cpu ticks", std ? 32'hC : 32'h6, 32'(t));
  endtask : mc_scn
  // ==========================================================
  // main sequence
  initial begin
    n_fail = 0;
    tests_run = 0;
    rst = 1'b1;
    {avs_read, avs_write, power_down} = 3'h0;
    clk_en = 1'b1;
    avs_address = '0;
    avs_writedata = '0;
    pin_drive = 8'h00;
    lvl_a = '0;
    lvl_b = '0;
    lvl_ref = '0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    tick(1);
    chk("wait idle", 32'h1, {31'h0, waitreq});
    port_scn();
    freeze_scn();
    cmp_one_scn();
    cmp_two_scn();
    mc_scn(1'b0, 8'h00, 6);
    mc_scn(1'b1, 8'h00, 12);
    mc_scn(1'b0, 8'h02, 18);
    mc_scn(1'b1, 8'h01, 24);
    close_out();
  end
endmodule : comparator_control_and_irq_tb_top
